// ### rtl/fri_defs.svh
// constants of the reset initialization sequencer
`ifndef FRI_DEFS_SVH
`define FRI_DEFS_SVH
`define FRI_OFF_STATUS 32'h0000_0000
`define FRI_OFF_CONFIG 32'h0000_0004
`define FRI_OFF_PROT 32'h0000_0008
`define FRI_OFF_OPTSEC 32'h0000_000C
`define FRI_OFF_CMD 32'h0000_0010
`define FRI_OFF_PARAM 32'h0000_0014
`define FRI_SEC_ADDR 18'h3FF0F
`define FRI_PARAM_ADDR 18'h3FF08
`define FRI_PROT_ADDR 18'h3FF0C
`define FRI_DPROT_ADDR 18'h3FF0D
`define FRI_OPT_ADDR 18'h3FF0E
`define FRI_DEF_PROT 8'h00
`define FRI_DEF_DPROT 8'h00
`define FRI_DEF_OPT 8'hFF
`define FRI_DEF_SEC 8'hFF
`define FRI_DEF_PARAM 8'h00
`define FRI_STAT_CMD_DONE 7
`define FRI_STAT_ACCERR 5
`define FRI_STAT_VERR1 1
`define FRI_STAT_VERR0 0
`define FRI_CFG_IRQ_EN 7
`define FRI_SEC_OPEN 2'b10
`define FRI_CMD_TIME_NS 2000
`define FRI_CMD_CYCLES ((`FRI_CMD_TIME_NS + 9) / 10)
`define FRI_STALL_FIRST 3'd1
`define FRI_STALL_LAST 3'd3
`endif

// ### rtl/fri_pkg.sv
// types of the reset initialization sequencer
package fri_pkg;
	typedef enum logic [2:0] {
		FRI_S_PARAM = 3'b000,
		FRI_S_PROT = 3'b001,
		FRI_S_DPROT = 3'b010,
		FRI_S_OPT = 3'b011,
		FRI_S_SEC = 3'b100,
		FRI_S_DONE = 3'b101
	} fri_step_e;
	typedef enum logic [1:0] {
		FRI_B_IDLE = 2'b00,
		FRI_B_WAIT = 2'b01,
		FRI_B_DATA = 2'b10
	} fri_bus_e;
	typedef struct packed {
		logic req;
		logic [17:0] addr;
	} fri_nvm_req_s;
	typedef struct packed {
		logic valid;
		logic [7:0] data;
		logic err;
		logic dbl;
	} fri_nvm_rsp_s;
endpackage

// ### rtl/fri_cfg_mem.sv
// configuration byte store with registered read data
module fri_cfg_mem #(
	parameter int DEPTH = 8
) (
	input wire logic mclk,
	input wire logic we,
	input wire logic [2:0] waddr,
	input wire logic [7:0] wdata,
	input wire logic [2:0] raddr,
	output logic [7:0] rdata
);
	if (DEPTH != 8) begin : g_bad_depth
		$error("depth must be 8");
	end
	logic [7:0] mem [DEPTH];
	always_ff @(posedge mclk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
		rdata <= mem[raddr];
	end
endmodule // fri_cfg_mem

// ### rtl/fri_init.sv
// reset initialization sequencer with ahb-lite register port
// Notes on behaviour
// - every reset loads parameters, both protections, option and security from array
// - any load error substitutes defaults: fully protected and secured
// - double-bit fault during the sequence sets both verify error bits
// - command complete flag stays zero throughout the sequence
// - bus accesses stall for part of the sequence, then reads resume
// - command complete flag rises at the end; commands accepted afterwards
// - reset during a program or erase aborts it immediately
// - command permission comes from operating mode and security state
// - security register loads from the security byte at its fixed address
// - disallowed command is rejected and sets the access error flag
// - command irq asserts while flag and its enable are both set
//
// Implementation choices: the register addresses and the AHB-Lite interface to the registers.
`include "fri_defs.svh"
module fri_init
	import fri_pkg::*;
#(
	parameter int CMD_CYCLES = `FRI_CMD_CYCLES
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	output fri_nvm_req_s nvm_req,
	input wire fri_nvm_rsp_s nvm_rsp,
	input wire logic special_mode,
	output logic cmd_irq,
	output logic [7:0] main_array_protection_reg,
	output logic [7:0] data_array_protection_reg,
	output logic [7:0] nvm_option_reg,
	output logic [7:0] security_state_reg,
	output logic init_done
);
	if (CMD_CYCLES < 1 || CMD_CYCLES > 65535) begin : g_bad_time
		$error("bad command time");
	end
	typedef struct packed {
		fri_step_e step;
		logic wait_rsp;
		logic any_err;
		logic [7:0] param;
		logic [7:0] prot;
		logic [7:0] dprot;
		logic [7:0] opt;
		logic [7:0] sec;
		logic [7:0] status;
		logic irq_en;
		logic [15:0] busy_cnt;
		logic [7:0] cmd_code;
		fri_bus_e bus;
		logic bwrite;
		logic [4:0] baddr;
		logic [31:0] rdata;
		logic readyout;
		logic irq;
		logic req;
		logic [17:0] req_addr;
		logic done;
	} fri_state_s;
	fri_state_s q, next_q;
	logic [1:0] mode_sync;
	logic [7:0] mem_rdata;
	logic mem_we;
	logic [2:0] mem_waddr;
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			mode_sync <= 2'b00;
		end else begin
			mode_sync <= {mode_sync[0], special_mode};
		end
	end
	fri_cfg_mem #(.DEPTH(8)) u_mem (
		.mclk(mclk),
		.we(mem_we),
		.waddr(mem_waddr),
		.wdata(nvm_rsp.data),
		.raddr(3'd0),
		.rdata(mem_rdata)
	);
	assign mem_we = q.wait_rsp && nvm_rsp.valid;
	assign mem_waddr = q.step;
	function automatic logic [17:0] step_addr(input fri_step_e s);
		unique case (s)
			FRI_S_PARAM: step_addr = `FRI_PARAM_ADDR;
			FRI_S_PROT: step_addr = `FRI_PROT_ADDR;
			FRI_S_DPROT: step_addr = `FRI_DPROT_ADDR;
			FRI_S_OPT: step_addr = `FRI_OPT_ADDR;
			FRI_S_SEC: step_addr = `FRI_SEC_ADDR;
			default: step_addr = 18'h00000;
		endcase
	endfunction
	// secured parts outside special mode may only run codes 1 to 3; code 0 is never allowed
	// security field 10 is the open state, every other code is secured
	function automatic logic cmd_allowed(input logic [7:0] c, input logic [7:0] s,
		input logic sp);
		cmd_allowed = (c != 8'h00) && (sp || (s[1:0] == `FRI_SEC_OPEN) || (c < 8'h04));
	endfunction
	logic stall;
	logic [7:0] b;
	always_comb begin
		next_q = q;
		b = nvm_rsp.data;
		stall = (q.step >= `FRI_STALL_FIRST) && (q.step <= `FRI_STALL_LAST);
		next_q.req = 1'b0;
		if (q.step != FRI_S_DONE) begin
			next_q.status[`FRI_STAT_CMD_DONE] = 1'b0;
			if (!q.wait_rsp) begin
				next_q.req = 1'b1;
				next_q.req_addr = step_addr(q.step);
				next_q.wait_rsp = 1'b1;
			end else if (nvm_rsp.valid) begin
				next_q.wait_rsp = 1'b0;
				if (nvm_rsp.dbl) begin
					next_q.status[`FRI_STAT_VERR1] = 1'b1;
					next_q.status[`FRI_STAT_VERR0] = 1'b1;
				end
				unique case (q.step)
					FRI_S_PARAM: next_q.param = b;
					FRI_S_PROT: next_q.prot = b;
					FRI_S_DPROT: next_q.dprot = b;
					FRI_S_OPT: next_q.opt = b;
					default: next_q.sec = b;
				endcase
				next_q.step = fri_step_e'(q.step + 3'd1);
				if (q.step == FRI_S_SEC) begin
					if (q.any_err || nvm_rsp.err || nvm_rsp.dbl) begin
						next_q.param = `FRI_DEF_PARAM;
						next_q.prot = `FRI_DEF_PROT;
						next_q.dprot = `FRI_DEF_DPROT;
						next_q.opt = `FRI_DEF_OPT;
						next_q.sec = `FRI_DEF_SEC;
					end
					next_q.status[`FRI_STAT_CMD_DONE] = 1'b1;
					next_q.done = 1'b1;
				end
				next_q.any_err = q.any_err || nvm_rsp.err || nvm_rsp.dbl;
			end
		end else if (q.busy_cnt != 16'd0) begin
			next_q.busy_cnt = q.busy_cnt - 16'd1;
			if (q.busy_cnt == 16'd1) begin
				next_q.status[`FRI_STAT_CMD_DONE] = 1'b1;
			end
		end
		// ahb-lite slave
		next_q.readyout = !stall;
		if (q.bus == FRI_B_DATA) begin
			next_q.bus = FRI_B_IDLE;
		end
		if (q.bus == FRI_B_WAIT && !stall) begin
			next_q.bus = FRI_B_DATA;
			next_q.readyout = 1'b1;
			if (q.bwrite) begin
				next_q.readyout = 1'b1;
			end
		end
		if (q.bus == FRI_B_DATA && q.bwrite) begin
			unique case (q.baddr)
				5'(`FRI_OFF_STATUS): begin
					if (hwdata[`FRI_STAT_ACCERR]) begin
						next_q.status[`FRI_STAT_ACCERR] = 1'b0;
					end
				end
				5'(`FRI_OFF_CONFIG): next_q.irq_en = hwdata[`FRI_CFG_IRQ_EN];
				5'(`FRI_OFF_CMD): begin
					if (q.status[`FRI_STAT_CMD_DONE]) begin
						if (cmd_allowed(hwdata[7:0], q.sec, mode_sync[1])) begin
							next_q.cmd_code = hwdata[7:0];
							next_q.status[`FRI_STAT_CMD_DONE] = 1'b0;
							next_q.status[`FRI_STAT_VERR1] = 1'b0;
							next_q.status[`FRI_STAT_VERR0] = 1'b0;
							next_q.busy_cnt = 16'(CMD_CYCLES);
						end else begin
							next_q.status[`FRI_STAT_ACCERR] = 1'b1;
						end
					end
				end
				default: ;
			endcase
		end
		if (hsel && hready && htrans[1] && q.bus != FRI_B_WAIT) begin
			next_q.bwrite = hwrite;
			next_q.baddr = haddr[4:0];
			if (stall) begin
				next_q.bus = FRI_B_WAIT;
				next_q.readyout = 1'b0;
			end else begin
				next_q.bus = FRI_B_DATA;
			end
			unique case (haddr[4:0])
				5'(`FRI_OFF_STATUS): next_q.rdata = {24'h000000, q.status};
				5'(`FRI_OFF_CONFIG): next_q.rdata = {24'h000000, q.irq_en, 7'h00};
				5'(`FRI_OFF_PROT): next_q.rdata = {16'h0000, q.dprot, q.prot};
				5'(`FRI_OFF_OPTSEC): next_q.rdata = {16'h0000, q.sec, q.opt};
				5'(`FRI_OFF_CMD): next_q.rdata = {24'h000000, q.cmd_code};
				5'(`FRI_OFF_PARAM): next_q.rdata = {24'h000000, mem_rdata};
				default: next_q.rdata = 32'h0000_0000;
			endcase
		end
		next_q.irq = next_q.status[`FRI_STAT_CMD_DONE] && next_q.irq_en;
	end
	// asynchronous reset drops busy_cnt, aborting any command at once
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			q <= '0;
			q.step <= FRI_S_PARAM;
			q.readyout <= 1'b1;
		end else begin
			q <= next_q;
		end
	end
	assign hrdata = q.rdata;
	assign hreadyout = q.readyout;
	assign hresp = 1'b0;
	assign nvm_req.req = q.req;
	assign nvm_req.addr = q.req_addr;
	assign cmd_irq = q.irq;
	assign main_array_protection_reg = q.prot;
	assign data_array_protection_reg = q.dprot;
	assign nvm_option_reg = q.opt;
	assign security_state_reg = q.sec;
	assign init_done = q.done;
endmodule // fri_init

// ### verification/fri_init_sva.sv
// port assertions for the reset initialization sequencer
module fri_init_chk
	import fri_pkg::*;
(
	input wire logic mclk,
	input wire logic rst,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire fri_nvm_req_s nvm_req,
	input wire fri_nvm_rsp_s nvm_rsp,
	input wire logic cmd_irq,
	input wire logic [7:0] main_array_protection_reg,
	input wire logic [7:0] security_state_reg,
	input wire logic init_done
);
	logic [17:0] last_addr;
	logic bad;
	logic [7:0] sec_byte;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			last_addr <= '0;
			bad <= 1'b0;
			sec_byte <= '0;
		end else begin
			if (nvm_req.req)
				last_addr <= nvm_req.addr;
			if (nvm_rsp.valid && (nvm_rsp.err || nvm_rsp.dbl))
				bad <= 1'b1;
			if (nvm_rsp.valid && last_addr == 18'h3FF0F)
				sec_byte <= nvm_rsp.data;
		end
	end
	sequence s_sec_req;
		nvm_req.req && nvm_req.addr == 18'h3FF0F;
	endsequence
	sequence s_sec_rsp;
		nvm_rsp.valid && last_addr == 18'h3FF0F;
	endsequence
	a_req_pulse: assert property (nvm_req.req |=> !nvm_req.req)
		else $error("fetch request held");
	a_next_fetch: assert property (nvm_rsp.valid && last_addr != 18'h3FF0F |-> ##[1:2] nvm_req.req)
		else $error("next fetch missing");
	a_sec_order: assert property (s_sec_req |-> last_addr == 18'h3FF0E)
		else $error("security fetch out of order");
	a_sec_load: assert property ($rose(init_done) && !bad |-> security_state_reg == sec_byte)
		else $error("security byte not loaded");
	a_default_fill: assert property ($rose(init_done) && bad |-> security_state_reg == 8'hFF && main_array_protection_reg == 8'h00)
		else $error("defaults not applied");
	a_quiet_init: assert property (!init_done |-> !cmd_irq)
		else $error("irq during sequence");
	a_done_after_sec: assert property (s_sec_rsp |-> ##[1:2] init_done)
		else $error("sequence end missing");
	a_done_holds: assert property (init_done |=> init_done)
		else $error("done dropped");
	a_stall_window: assert property (!hreadyout |-> !init_done)
		else $error("stall after sequence");
	a_stall_bound: assert property (!hreadyout |-> ##[1:1000] hreadyout)
		else $error("stall never released");
	a_resp_okay: assert property (!hresp)
		else $error("error response seen");
endmodule // fri_init_chk
bind fri_init fri_init_chk u_chk (.mclk(mclk), .rst(rst), .hreadyout(hreadyout),
	.hresp(hresp), .nvm_req(nvm_req), .nvm_rsp(nvm_rsp), .cmd_irq(cmd_irq),
	.main_array_protection_reg(main_array_protection_reg),
	.security_state_reg(security_state_reg), .init_done(init_done));

// ### verification/fri_nvm_model.sv
// config array stand-in answering fetch requests
module fri_nvm_model
	import fri_pkg::*;
(
	input wire logic mclk,
	input wire fri_nvm_req_s nvm_req,
	input wire logic [1:0] fault,
	input wire logic [3:0] lat,
	output fri_nvm_rsp_s nvm_rsp
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [17:0] a;
	int n = -1;
	initial nvm_rsp = '0;
	always @(posedge mclk) begin
		nvm_rsp.valid <= 1'b0;
		nvm_rsp.data <= ~nvm_rsp.data;
		if (nvm_req.req) begin
			a <= nvm_req.addr;
			n <= lat;
		end else if (n > 0)
			n <= n - 1;
		else if (n == 0) begin
			nvm_rsp <= {1'b1, a[7:0] ^ 8'hA5, fault};
			n <= -1;
		end
	end
endmodule // fri_nvm_model

// ### verification/tb_flash_reset_initializer.sv
// self-checking bench for the reset initialization sequencer
module tb_flash_reset_initializer;
	import fri_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk;
	logic rst = 1'b1;
	logic hsel = 1'b0;
	logic [31:0] haddr = '0;
	logic [1:0] htrans = '0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'b010;
	logic [31:0] hwdata = '0;
	logic special_mode = 1'b0;
	logic [1:0] fault = '0;
	logic [3:0] lat = 4'h4;
	logic [31:0] hrdata;
	logic [31:0] rd;
	logic hreadyout;
	logic cmd_irq;
	logic init_done;
	logic [7:0] mp, dp, op, sp;
	fri_nvm_req_s nvm_req;
	fri_nvm_rsp_s nvm_rsp;
	int fail_count = 0;
	int n_compared = 0;
	fri_init #(.CMD_CYCLES(20)) u_dut (.mclk(mclk), .rst(rst), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(),
		.nvm_req(nvm_req), .nvm_rsp(nvm_rsp), .special_mode(special_mode),
		.cmd_irq(cmd_irq), .main_array_protection_reg(mp), .data_array_protection_reg(dp),
		.nvm_option_reg(op), .security_state_reg(sp), .init_done(init_done));
	fri_nvm_model u_nvm (.mclk(mclk), .nvm_req(nvm_req), .fault(fault), .lat(lat),
		.nvm_rsp(nvm_rsp));
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	task automatic complete_run();
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			fail_count++;
			$display("[ERR] %s exp %h seen %h", n, e, g);
		end
	endtask
	task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= a;
		hwrite <= w;
		@(posedge mclk);
		while (hreadyout !== 1'b1) @(posedge mclk);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		@(posedge mclk);
		while (hreadyout !== 1'b1) @(posedge mclk);
		rd = hrdata;
	endtask
	task automatic rc(input string n, input logic [31:0] a, m, e);
		bus(1'b0, a, 32'h0);
		chk(n, e, rd & m);
	endtask
	task automatic do_rst(input logic [1:0] f);
		fault <= f;
		rst <= 1'b1;
		repeat (3) @(posedge mclk);
		rst <= 1'b0;
	endtask
	task automatic wait_done();
		while (init_done !== 1'b1) @(posedge mclk);
	endtask
	initial begin
		do_rst(2'b00);
		@(posedge mclk);
		rc("done_busy", 32'h0, 32'h80, 32'h0);
		wait_done();
		chk("prot", 32'hA9, mp);
		chk("sec", 32'hAA, sp);
		chk("dprot", 32'hA8, dp);
		rc("prot_pair", 32'h8, 32'hFFFF, 32'hA8A9);
		rc("opt_sec", 32'hC, 32'hFFFF, 32'hAAAB);
		rc("param", 32'h14, 32'hFF, 32'hAD);
		rc("done_set", 32'h0, 32'hA3, 32'h80);
		bus(1'b1, 32'h4, 32'h80);
		repeat (2) @(posedge mclk);
		chk("irq_on", 32'h1, cmd_irq);
		bus(1'b1, 32'h10, 32'h5);
		rc("cmd_run", 32'h0, 32'h80, 32'h0);
		chk("irq_off", 32'h0, cmd_irq);
		repeat (30) @(posedge mclk);
		rc("cmd_end", 32'h0, 32'h80, 32'h80);
		$display("test load done");
		lat <= 4'h0;
		bus(1'b1, 32'h10, 32'h5);
		do_rst(2'b11);
		wait_done();
		chk("def_prot", 32'h0, mp);
		chk("def_opt", 32'hFF, op);
		chk("def_sec", 32'hFF, sp);
		rc("verify", 32'h0, 32'hA3, 32'h83);
		$display("test fault done");
		bus(1'b1, 32'h10, 32'h5);
		rc("refused", 32'h0, 32'hA0, 32'hA0);
		bus(1'b1, 32'h0, 32'h20);
		rc("err_clr", 32'h0, 32'hA0, 32'h80);
		bus(1'b1, 32'h10, 32'h2);
		rc("low_code", 32'h0, 32'h80, 32'h0);
		repeat (30) @(posedge mclk);
		special_mode <= 1'b1;
		repeat (3) @(posedge mclk);
		bus(1'b1, 32'h10, 32'h5);
		rc("special", 32'h0, 32'h80, 32'h0);
		$display("test modes done");
		complete_run();
	end
	initial begin
		#50us;
		fail_count++;
		$display("[ERR] watchdog exp finish seen hang");
		complete_run();
	end
endmodule // tb_flash_reset_initializer
